//--- hdl/cam_pkg.sv
/*
 * package for the content-addressable search block: sizes, modes,
 * write timing and the preload image used at configuration.
 * assumes a single user clock domain around the block.
 */
package cam_pkg;
    localparam int unsigned       WORDS       = 32;
    localparam int unsigned       WIDTH       = 32;
    localparam int unsigned       AW          = 5;
    localparam int unsigned       LANES       = 16;
    localparam logic [1:0]        WR_CYC_PLN  = 2'h2;
    localparam logic [1:0]        WR_CYC_DC   = 2'h3;
    localparam logic [WIDTH-1:0]  INIT_DATA   = 32'h00000000;
    localparam logic [WIDTH-1:0]  INIT_CARE   = 32'h00000000;
    typedef enum logic {CAM_ENC, CAM_UNENC} cam_mode_t;
    typedef enum logic [1:0] {CAM_IDLE, CAM_WRITE, CAM_HALF} cam_st_t;
endpackage

//--- hdl/cam_search_block.sv
/*
 * content-addressable search block: 32 entries of 32 bits, each bit with
 * its own care flag, searched in parallel; encoded or unencoded result.
 * write path: request, then two or three busy cycles, then a done pulse.
 * search path: one result cycle, or two when the lines are unencoded.
 * assumes user logic on clk_sys drives all requests synchronously.
 * assumes requests come only while the block is idle; a request made
 * while busy or mid-result is dropped and must be raised again.
 * assumes the reset image stands in for the configuration preload.
 * limitation: the encoded address of a duplicated key is meaningless,
 * so such users should read the unencoded lines instead.
 */
// Functional notes
// - 32 entries of 32 bits; the key is compared against every one.
// - bits stored as don't-care are ignored in the comparison.
// - encoded mode reports the binary address of the matching entry.
// - unencoded mode shows 32 lines on 16 outputs over two cycles.
// - unencoded mode raises the line of every matching entry.
// - entries preload at configuration and are writable while running.
// - write takes two cycles, three when the word has don't-care bits.

`timescale 1ns/1ps
module cam_search_block
(
    input  wire logic                            clk_sys,
    input  wire logic                            resetn,
    input  wire logic                            mode_unenc,
    input  wire logic                            wr_req,
    input  wire logic [cam_pkg::AW-1:0]          wr_addr,
    input  wire logic [cam_pkg::WIDTH-1:0]       wr_data,
    input  wire logic [cam_pkg::WIDTH-1:0]       wr_dc,
    input  wire logic                            srch_req,
    input  wire logic [cam_pkg::WIDTH-1:0]       srch_key,
    output logic                                 wr_busy,
    output logic                                 wr_done,
    output logic                                 res_valid,
    output logic                                 res_hit,
    output logic [cam_pkg::AW-1:0]               res_addr,
    output logic [cam_pkg::LANES-1:0]            res_lines,
    output logic                                 res_upper
);

    // ==========================================================
    // state
    // one packed record holds every flop of the block; the comb
    // process builds its next copy and one clocked process stores it
    typedef struct packed {
        // sequencing and write staging
        cam_pkg::cam_st_t                          st;
        logic [1:0]                                cnt;
        logic [1:0]                                need;
        logic [cam_pkg::AW-1:0]                    waddr;
        logic [cam_pkg::WIDTH-1:0]                 wdata;
        logic [cam_pkg::WIDTH-1:0]                 wcare;
        // stored entries, their care masks and the parked high half of the lines
        logic [cam_pkg::WORDS-1:0][cam_pkg::WIDTH-1:0] data;
        logic [cam_pkg::WORDS-1:0][cam_pkg::WIDTH-1:0] care;
        logic [cam_pkg::LANES-1:0]                 hi_half;
        // flags and results shown on the ports
        logic                                      busy;
        logic                                      done;
        logic                                      valid;
        logic                                      hit;
        logic [cam_pkg::AW-1:0]                    addr;
        logic [cam_pkg::LANES-1:0]                 lines;
        logic                                      upper;
    } cam_state_t;

    // registered copy and its next value
    cam_state_t                                    s_ff;
    cam_state_t                                    nxt_s;

    // ==========================================================
    // helpers
    // one entry matches when every cared bit equals the key
    // a bit with its care flag low can neither make nor break a match
    function automatic logic cam_match(
        input logic [cam_pkg::WIDTH-1:0] d,
        input logic [cam_pkg::WIDTH-1:0] c,
        input logic [cam_pkg::WIDTH-1:0] k
    );
        cam_match = ~|((d ^ k) & c);
    endfunction

    // lowest matching index; only meaningful for a single match
    // scanned downward so the last index kept is the lowest hit
    // with duplicates stored, this index is arbitrary to the user
    function automatic logic [cam_pkg::AW-1:0] cam_enc(
        input logic [cam_pkg::WORDS-1:0] m
    );
        cam_enc = '0;
        for (int i = cam_pkg::WORDS - 1; i >= 0; i--)
        begin
            if (m[i])
            begin
                cam_enc = cam_pkg::AW'(i);
            end
        end
    endfunction

    // ==========================================================
    // next state
    always_comb
    begin
        logic [cam_pkg::WORDS-1:0] m;
        m     = '0;
        nxt_s = s_ff;
        // pulses last one cycle; every other field holds unless set
        nxt_s.done  = 1'b0;
        nxt_s.valid = 1'b0;
        // parallel compare of key against all entries
        for (int i = 0; i < cam_pkg::WORDS; i++)
        begin
            m[i] = cam_match(s_ff.data[i], s_ff.care[i], srch_key);
        end
        case (s_ff.st)
            cam_pkg::CAM_IDLE:
            begin
                // a write wins over a search raised in the same cycle
                if (wr_req)
                begin
                    nxt_s.st    = cam_pkg::CAM_WRITE;
                    nxt_s.cnt   = 2'h1;
                    nxt_s.waddr = wr_addr;
                    nxt_s.wdata = wr_data;
                    // care is stored as the inverse of the don't-care mask
                    nxt_s.wcare = ~wr_dc;
                    // a word with any don't-care bit needs a third cycle
                    nxt_s.need  = (|wr_dc) ? cam_pkg::WR_CYC_DC
                                           : cam_pkg::WR_CYC_PLN;
                    nxt_s.busy  = 1'b1;
                end
                else if (srch_req)
                begin
                    // hit and address are held until the next result
                    nxt_s.valid = 1'b1;
                    nxt_s.hit   = |m;
                    nxt_s.addr  = cam_enc(m);
                    // the first result cycle always shows the low half
                    nxt_s.upper = 1'b0;
                    if (mode_unenc == cam_pkg::CAM_UNENC)
                    begin
                        // low half now, high half parked for next cycle
                        nxt_s.lines   = m[cam_pkg::LANES-1:0];
                        nxt_s.hi_half = m[cam_pkg::WORDS-1:cam_pkg::LANES];
                        nxt_s.st      = cam_pkg::CAM_HALF;
                    end
                    else
                    begin
                        // encoded results leave the lines low
                        nxt_s.lines = '0;
                    end
                end
            end
            cam_pkg::CAM_HALF:
            begin
                // second cycle shows entries 16..31
                // requests are ignored here; the user waits one cycle
                nxt_s.valid = 1'b1;
                nxt_s.upper = 1'b1;
                nxt_s.lines = s_ff.hi_half;
                nxt_s.st    = cam_pkg::CAM_IDLE;
            end
            cam_pkg::CAM_WRITE:
            begin
                // count busy cycles; commit on the last one
                if (s_ff.cnt == s_ff.need)
                begin
                    // entry and mask change together in the last cycle
                    // searches wait, so none sees a half-written entry
                    nxt_s.data[s_ff.waddr] = s_ff.wdata;
                    nxt_s.care[s_ff.waddr] = s_ff.wcare;
                    nxt_s.busy = 1'b0;
                    nxt_s.done = 1'b1;
                    nxt_s.st   = cam_pkg::CAM_IDLE;
                end
                else
                begin
                    nxt_s.cnt = s_ff.cnt + 2'h1;
                end
            end
            default:
            begin
                // unused encoding; fall back to idle
                nxt_s.st = cam_pkg::CAM_IDLE;
            end
        endcase
    end

    // ==========================================================
    // registers; reset stands for the configuration preload
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            // outputs start low; every entry takes the preload image
            s_ff       <= '0;
            s_ff.st    <= cam_pkg::CAM_IDLE;
            s_ff.data  <= {cam_pkg::WORDS{cam_pkg::INIT_DATA}};
            s_ff.care  <= {cam_pkg::WORDS{cam_pkg::INIT_CARE}};
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    // ==========================================================
    // outputs
    // every port is a field of the state register, so no logic
    // sits between the flops and the pins
    // write status
    assign wr_busy   = s_ff.busy;
    assign wr_done   = s_ff.done;

    // search result
    assign res_valid = s_ff.valid;
    assign res_hit   = s_ff.hit;
    assign res_addr  = s_ff.addr;
    assign res_lines = s_ff.lines;
    assign res_upper = s_ff.upper;
endmodule

//--- bench/cam_chk_asserts.sv
/*
 * port checker for cam_search_block: write timing, refused searches and
 * the shape of encoded and unencoded results.
 * assumes it is bound into the block and sees only its ports; the bind
 * stands at the foot of this file.
 */
`timescale 1ns/1ps
module cam_chk
(
    input wire logic        clk_sys,
    input wire logic        resetn,
    input wire logic        mode_unenc,
    input wire logic        wr_req,
    input wire logic        srch_req,
    input wire logic        wr_busy,
    input wire logic        wr_done,
    input wire logic        res_valid,
    input wire logic        res_hit,
    input wire logic        res_upper,
    input wire logic [31:0] wr_dc,
    input wire logic [15:0] res_lines
);
    logic m_ff; // last search taken was unencoded
    wire  idle = !wr_busy && !(res_valid && !res_upper && m_ff);
    wire  go = srch_req && !wr_req && idle;
    wire  wq = wr_req && idle;
    always_ff @(posedge clk_sys or negedge resetn)
        if (!resetn)
            m_ff <= 1'b0;
        else if (go)
            m_ff <= mode_unenc;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    property p_w2; wq && !wr_dc |=> wr_busy[*2] ##1 wr_done; endproperty
    a_w2: assert property (p_w2) else $error("plain write");
    property p_w3; wq && wr_dc |=> wr_busy[*3] ##1 wr_done; endproperty
    a_w3: assert property (p_w3) else $error("masked write");
    property p_rf; srch_req && (wr_busy || wq) |=> !res_valid; endproperty
    a_rf: assert property (p_rf) else $error("search taken");
    property p_en; go && !mode_unenc |=> res_valid && !res_lines; endproperty
    a_en: assert property (p_en) else $error("encoded");
    property p_un; go && mode_unenc |=>
        res_valid && !res_upper ##1 res_valid && res_upper; endproperty
    a_un: assert property (p_un) else $error("unencoded");
    property p_up; res_valid && res_upper |=> !res_valid || !res_upper;
    endproperty
    a_up: assert property (p_up) else $error("upper half");
    property p_hi; res_valid && res_lines |-> res_hit; endproperty
    a_hi: assert property (p_hi) else $error("line no hit");
    property p_ms; res_valid && !res_hit |-> !res_lines; endproperty
    a_ms: assert property (p_ms) else $error("miss lines");
    cover property (wq && wr_dc);
    cover property (go && mode_unenc);
    cover property (srch_req && wq);
endmodule
bind cam_search_block cam_chk u_chk (.*);

//--- bench/cam_user.sv
/*
 * user-side model: issues writes and searches to the block.
 * assumes the block samples on rising clk_sys edges; every field is
 * changed by non-blocking assignment at an edge and held until taken.
 */
`timescale 1ns/1ps
module cam_user
(
    input wire logic    clk_sys,
    input wire logic    wr_done,
    output logic        mode_unenc,
    output logic        wr_req,
    output logic        srch_req,
    output logic [4:0]  wr_addr,
    output logic [31:0] wr_data,
    output logic [31:0] wr_dc,
    output logic [31:0] srch_key
);
    initial {mode_unenc, wr_req, srch_req, wr_addr, wr_data, wr_dc,
             srch_key} = '0;
    // write with a colliding search; fields held until commit
    task automatic wr(input logic [4:0] a, input logic [31:0] d, k,
                      output int n);
        @(posedge clk_sys);
        {wr_req, srch_req, wr_addr, wr_data, wr_dc} <= {2'h3, a, d, k};
        @(posedge clk_sys);
        {wr_req, srch_req} <= 2'h0;
        n = 0;
        do
            @(posedge clk_sys) #1 n++;
        while (!wr_done && n < 5);
    endtask
    task automatic sr(input logic [31:0] k, input logic m);
        @(posedge clk_sys);
        {srch_req, srch_key, mode_unenc} <= {1'b1, k, m};
        @(posedge clk_sys);
        srch_req <= 1'b0;
    endtask
endmodule

//--- bench/tb_top.sv
/*
 * bench: random writes and searches against an array model, with one
 * reset in mid-run to bring back the preload image.
 * assumes the user model and the bound checker sit beside the block.
 */
`timescale 1ns/1ps
module tb_top;
    logic        clk_sys, resetn, mode_unenc, wr_req, srch_req, wr_busy;
    logic        wr_done, res_valid, res_hit, res_upper;
    logic [4:0]  wr_addr, res_addr;
    logic [15:0] res_lines;
    logic [31:0] wr_data, wr_dc, srch_key, d, c, e, md[32], mc[32];
    int          n_fail, cmp_count, seed, r, i, n, a;
    cam_search_block dut (.*);
    cam_user         u (.*);
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    task automatic chk(input string s, input logic [31:0] x, y);
        cmp_count++;
        n_fail += (x !== y);
        if (x !== y)
            $display("unexpected %s: expected %h seen %h", s, x, y);
    endtask
    task automatic report_and_stop();
        if (n_fail == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // one search checked against the model
    task automatic search(input logic [31:0] k, input logic m);
        u.sr(k, m);
        for (int j = 31; j >= 0; j--)
        begin
            e[j] = ((md[j] ^ k) & ~mc[j]) == 0;
            if (e[j])
                a = j;
        end
        // first result cycle stands just after the taking edge
        #1;
        chk("valid", 32'h1, res_valid);
        chk("half", 32'h0, res_upper);
        chk("hit", 32'(|e), res_hit);
        chk("lines", m ? e[15:0] : 16'h0, res_lines);
        if (!m && $countones(e) == 1)
            chk("addr", a, res_addr);
        @(posedge clk_sys) #1 chk("valid2", 32'(m), res_valid);
        if (m)
        begin
            chk("half2", 32'h1, res_upper);
            chk("upper", e[31:16], res_lines);
        end
    endtask
    initial
    begin
        seed = 32'ha48f;
        resetn = 1'b0;
        for (i = 0; i < 32; i++)
            {md[i], mc[i]} = {cam_pkg::INIT_DATA, ~cam_pkg::INIT_CARE};
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        for (r = 0; r < 240; r++)
        begin
            // mid-run reset brings back the preload image
            if (r == 120)
            begin
                resetn <= 1'b0;
                @(posedge clk_sys);
                resetn <= 1'b1;
                for (i = 0; i < 32; i++)
                    {md[i], mc[i]} = {cam_pkg::INIT_DATA, ~cam_pkg::INIT_CARE};
            end
            d = $random(seed) & 32'h8000000f;
            c = $random(seed) & $random(seed) & 32'h80000003;
            i = $random(seed) & 31;
            if (r % 3 != 1)
                search(d, c[0]);
            else
            begin
                u.wr(i[4:0], d, c, n);
                {md[i], mc[i]} = {d, c};
                chk("cycles", (c != 0) ? 3 : 2, n);
                chk("busy", 32'h0, wr_busy);
            end
        end
        report_and_stop();
    end
    // watchdog for a stalled handshake
    initial
    begin
        #20000;
        n_fail++;
        report_and_stop();
    end
endmodule
